// >>> pwm_back_pkg.sv
// Constants and carriers for the pulse output back end
package pwm_back_pkg;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_FORCE = 8'h00;
	localparam logic [7:0] OFS_RELOAD = 8'h04;
	localparam logic [7:0] OFS_PRESCALE = 8'h08;
	localparam logic [7:0] OFS_EXT = 8'h0C;
	localparam logic [7:0] OFS_INIT = 8'h10;
	localparam logic [7:0] OFS_TSEL = 8'h14;
	localparam logic [7:0] OFS_DEADBAND_CONTROL = 8'h18;
	localparam logic [7:0] OFS_RED = 8'h1C;
	localparam logic [7:0] OFS_FED = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [15:0] REG_RST = 16'h0000;
	// Field positions; channel B sits one step above channel A, except the group bit, which sits one bit above
	localparam int POS_RLD = 0;
	localparam int POS_PSSEL = 5;
	localparam int POS_BPRD = 8;
	localparam int POS_BCNT = 10;
	localparam int BAS_STEP = 4;
	localparam int POS_XPRD = 0;
	localparam int POS_XCNT = 4;
	localparam int EXT_STEP = 8;
	localparam int POS_INIT = 0;
	localparam int POS_TGRP = 4;
	localparam int POS_TSRC = 8;
	localparam int POS_TEN = 11;
	localparam int TSEL_STEP = 4;
	localparam int POS_OUTM = 0;
	localparam int POS_POL = 2;
	localparam int POS_INM = 4;
	localparam int POS_LDRED = 6;
	localparam int POS_LDFED = 8;
	localparam int POS_SWAP = 12;
	localparam int POS_DEDB = 14;
	localparam int POS_HALF = 15;
	// Action and force codes
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TGL = 2'h3;
	// Reload event select codes
	localparam logic [1:0] RLD_ZERO = 2'h0;
	localparam logic [1:0] RLD_PRD = 2'h1;
	localparam logic [1:0] RLD_BOTH = 2'h2;
	// Trigger source codes
	localparam logic [2:0] SRC_ZERO = 3'h1;
	localparam logic [2:0] SRC_PRD = 3'h2;
	localparam logic [2:0] SRC_ZP = 3'h3;
	localparam logic [2:0] SRC_CA_UP = 3'h4;
	localparam logic [2:0] SRC_CA_DN = 3'h5;
	localparam logic [2:0] SRC_CB_UP = 3'h6;
	localparam logic [2:0] SRC_CB_DN = 3'h7;
	// Output swap codes
	localparam logic [1:0] SWP_A = 2'h1;
	localparam logic [1:0] SWP_B = 2'h2;
	localparam logic [1:0] SWP_CROSS = 2'h3;
	// Time-base and compare events as one-cycle pulses, plus the down_mode level
	typedef struct packed {
		logic zero;
		logic period;
		logic cmp_a_up;
		logic cmp_a_dn;
		logic cmp_b_up;
		logic cmp_b_dn;
		logic cmp_c_up;
		logic cmp_c_dn;
		logic cmp_d_up;
		logic cmp_d_dn;
		logic down_mode;
	} tb_evt_s;
	// Qualifier actions per output; level is used outside down-count
	typedef struct packed {
		logic [1:0] zero;
		logic [1:0] t1d;
		logic [1:0] t2d;
		logic [1:0] cbd;
		logic [1:0] cad;
		logic [1:0] prd;
		logic level;
	} aq_evt_s;
endpackage

// >>> pwm_force_trigger_deadband.sv
// Force, event trigger and dead-band back end of a pulse channel
// Operation
// [R01] Force code 01 low, 10 high, else none
// [R02] Force reaches output one clock later; the registered pin drivers add a second clock
// [R03] Force setting shadowed, reloaded at zero/period
// [R04] No immediate force load offered
// [R05] Down-count: period event has lowest priority
// [R06] Down order: force, zero, T1, T2, CB, CA
// [R07] Each trigger channel has 4-bit counter
// [R08] Source select picks counting event
// [R09] Group bit picks compares A/B or C/D
// [R10] Pair select picks basic or extended prescale
// [R11] Period field sets events per trigger
// [R12] Trigger needs period reached and enable set
// [R13] Enables gate each channel independently
// [R14] Counters start from initialisation register
// [R15] Source 100 counts compare A events
// [R16] Edges delayed by programmed clock counts
// [R17] Half-period bit doubles delay resolution
// [R18] Delays shadowed, loaded on chosen event
// [R19] Input select, polarity and path select
// [R20] Swap bits route A and B paths
// [R21] Dual edge delays one source onto B
// [R22] Software keeps output A valid in dual mode
// [R23] Counter returns to zero after trigger
// [R24] Delay restarts on each edge
`timescale 1ns/1ps
module pwm_force_trigger_deadband
	import pwm_back_pkg::*;
#(
	parameter int DLY_W = 14
) (
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Time-base events and qualifier actions
	input wire tb_evt_s tb_evt_i,
	input wire aq_evt_s aq_a_i,
	input wire aq_evt_s aq_b_i,
	// Power stage and converter trigger
	output logic pulse_output_a_o,
	output logic pulse_output_b_o,
	output logic [1:0] conversion_trigger_out_o
);
	logic [3:0] csf_shd_r;
	logic [3:0] csf_act_r;
	logic [15:0] rld_r;
	logic [15:0] pre_r;
	logic [15:0] ext_r;
	logic [15:0] init_r;
	logic [15:0] tsel_r;
	logic [15:0] db_r;
	logic [DLY_W-1:0] red_shd_r;
	logic [DLY_W-1:0] fed_shd_r;
	logic [DLY_W-1:0] red_act_r;
	logic [DLY_W-1:0] fed_act_r;
	logic [1:0] aq_state_r;
	logic [1:0] aq_nxt;
	logic [3:0] cnt_r [2];
	logic [3:0] prd_sel [2];
	logic [1:0] src_hit;
	logic [1:0] trig_r;
	logic [1:0] dly_in;
	logic [1:0] dly_out_r;
	logic red_out;
	logic fed_out;
	logic path_a;
	logic path_b;
	logic fin_a;
	logic fin_b;
	logic wr_en;
	logic [31:0] rd_data;
	logic rd_err;
	logic [ADDR_W-1:0] ofs;

	// Reload strobe for a two-bit event select
	function automatic logic reload_hit(logic [1:0] m, tb_evt_s e);
		return (m == RLD_ZERO && e.zero) || (m == RLD_PRD && e.period) ||
			(m == RLD_BOTH && (e.zero || e.period));
	endfunction

	// Apply one qualifier action to a level
	function automatic logic apply_act(logic [1:0] a, logic cur);
		logic v;
		v = cur;
		case (a)
			ACT_LOW: v = 1'b0;
			ACT_HIGH: v = 1'b1;
			ACT_TGL: v = ~cur;
			default: v = cur;
		endcase
		return v;
	endfunction

	// Highest-priority down-count action; period comes last
	function automatic logic [1:0] pick_dn(aq_evt_s e);
		logic [1:0] a;
		a = e.prd;
		if (e.zero != 2'h0) begin
			a = e.zero;
		end else if (e.t1d != 2'h0) begin
			a = e.t1d;
		end else if (e.t2d != 2'h0) begin
			a = e.t2d;
		end else if (e.cbd != 2'h0) begin
			a = e.cbd;
		end else if (e.cad != 2'h0) begin
			a = e.cad;
		end
		return a;
	endfunction

	// Event chosen for a trigger counter
	function automatic logic pick_src(logic [2:0] s, logic g, tb_evt_s e);
		logic h;
		case (s)
			SRC_ZERO: h = e.zero;
			SRC_PRD: h = e.period;
			SRC_ZP: h = e.zero || e.period;
			// [R15] compare A source
			SRC_CA_UP: h = g ? e.cmp_c_up : e.cmp_a_up;
			SRC_CA_DN: h = g ? e.cmp_c_dn : e.cmp_a_dn;
			SRC_CB_UP: h = g ? e.cmp_d_up : e.cmp_b_up;
			SRC_CB_DN: h = g ? e.cmp_d_dn : e.cmp_b_dn;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// APB decode; one wait-free access when enabled
	assign ofs = paddr_i;
	assign wr_en = ce_i && psel_i && penable_i && pwrite_i;
	assign pready_o = ce_i;

	// Register writes
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			csf_shd_r <= 4'h0;
			rld_r <= REG_RST;
			pre_r <= REG_RST;
			ext_r <= REG_RST;
			init_r <= REG_RST;
			tsel_r <= REG_RST;
			db_r <= REG_RST;
			red_shd_r <= '0;
			fed_shd_r <= '0;
		end else if (wr_en) begin
			if (ofs == OFS_FORCE) begin
				csf_shd_r <= pwdata_i[3:0];
			end else if (ofs == OFS_RELOAD) begin
				rld_r <= pwdata_i[15:0];
			end else if (ofs == OFS_PRESCALE) begin
				pre_r <= pwdata_i[15:0];
			end else if (ofs == OFS_EXT) begin
				ext_r <= pwdata_i[15:0];
			end else if (ofs == OFS_INIT) begin
				init_r <= pwdata_i[15:0];
			end else if (ofs == OFS_TSEL) begin
				tsel_r <= pwdata_i[15:0];
			end else if (ofs == OFS_DEADBAND_CONTROL) begin
				db_r <= pwdata_i[15:0];
			end else if (ofs == OFS_RED) begin
				red_shd_r <= pwdata_i[DLY_W-1:0];
			end else if (ofs == OFS_FED) begin
				fed_shd_r <= pwdata_i[DLY_W-1:0];
			end
		end
	end

	// Read mux with live counter and output state
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (ofs == OFS_FORCE) begin
			rd_data[3:0] = csf_shd_r;
		end else if (ofs == OFS_RELOAD) begin
			rd_data[15:0] = rld_r;
		end else if (ofs == OFS_PRESCALE) begin
			rd_data[15:0] = pre_r;
			rd_data[POS_BCNT +: 2] = cnt_r[0][1:0];
			rd_data[POS_BCNT+BAS_STEP +: 2] = cnt_r[1][1:0];
		end else if (ofs == OFS_EXT) begin
			rd_data[15:0] = ext_r;
			rd_data[POS_XCNT +: 4] = cnt_r[0];
			rd_data[POS_XCNT+EXT_STEP +: 4] = cnt_r[1];
		end else if (ofs == OFS_INIT) begin
			rd_data[15:0] = init_r;
		end else if (ofs == OFS_TSEL) begin
			rd_data[15:0] = tsel_r;
		end else if (ofs == OFS_DEADBAND_CONTROL) begin
			rd_data[15:0] = db_r;
		end else if (ofs == OFS_RED) begin
			rd_data[DLY_W-1:0] = red_shd_r;
		end else if (ofs == OFS_FED) begin
			rd_data[DLY_W-1:0] = fed_shd_r;
		end else if (ofs == OFS_STATUS) begin
			rd_data[7:0] = {pulse_output_b_o, pulse_output_a_o, trig_r,
				csf_act_r};
		end else begin
			rd_err = 1'b1;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (ce_i && psel_i && !penable_i) begin
			prdata_o <= rd_data;
			pslverr_o <= rd_err;
		end
	end

	// [R03] [R04] force setting shadow reload
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			csf_act_r <= 4'h0;
		end else if (ce_i && reload_hit(rld_r[POS_RLD +: 2], tb_evt_i)) begin
			csf_act_r <= csf_shd_r;
		end
	end

	property p_force_reload;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ce_i && tb_evt_i.zero && rld_r[1:0] == RLD_ZERO)
			|=> csf_act_r == $past(csf_shd_r);
	endproperty
	a_force_reload: assert property (p_force_reload) // [R03]
		else $error("force setting not reloaded at zero");

	property p_force_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!tb_evt_i.zero && !tb_evt_i.period) |=> $stable(csf_act_r);
	endproperty
	a_force_hold: assert property (p_force_hold) // [R04]
		else $error("force setting changed without event");

	// [R01] [R06] force first, then down-count priority
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic [1:0] f;
			aq_evt_s e;
			f = csf_act_r[2*c +: 2];
			e = (c == 0) ? aq_a_i : aq_b_i;
			if (f == ACT_LOW) begin
				aq_nxt[c] = 1'b0;
			end else if (f == ACT_HIGH) begin
				aq_nxt[c] = 1'b1;
			end else if (tb_evt_i.down_mode) begin
				// [R05] period event lowest
				aq_nxt[c] = apply_act(pick_dn(e), aq_state_r[c]);
			end else begin
				aq_nxt[c] = e.level;
			end
		end
	end

	// [R02] qualified level registered one clock later
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aq_state_r <= 2'h0;
		end else if (ce_i) begin
			aq_state_r <= aq_nxt;
		end
	end

	property p_force_low;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ce_i && csf_act_r[1:0] == ACT_LOW) |=> !aq_state_r[0];
	endproperty
	a_force_low: assert property (p_force_low) // [R01]
		else $error("forced low not applied to output A");

	property p_force_high;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ce_i && csf_act_r[3:2] == ACT_HIGH) |=> aq_state_r[1];
	endproperty
	a_force_high: assert property (p_force_high) // [R02]
		else $error("forced high not on output B one clock later");

	// [R08] [R09] [R10] source and prescale pair select
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			src_hit[c] = pick_src(tsel_r[POS_TSRC+TSEL_STEP*c +: 3],
				tsel_r[POS_TGRP+c], tb_evt_i);
			if (pre_r[POS_PSSEL]) begin
				prd_sel[c] = ext_r[POS_XPRD+EXT_STEP*c +: 4];
			end else begin
				prd_sel[c] = {2'h0, pre_r[POS_BPRD+BAS_STEP*c +: 2]};
			end
		end
	end

	// [R07] [R11] [R14] [R23] event counters and trigger pulses
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r[0] <= 4'h0;
			cnt_r[1] <= 4'h0;
			trig_r <= 2'h0;
		end else if (ce_i) begin
			for (int c = 0; c < 2; c++) begin
				trig_r[c] <= 1'b0;
				if (wr_en && ofs == OFS_INIT) begin
					cnt_r[c] <= pwdata_i[POS_INIT+EXT_STEP*c +: 4];
				end else if (src_hit[c]) begin
					if (prd_sel[c] != 4'h0 && 4'(cnt_r[c] + 4'h1) >= prd_sel[c]) begin
						cnt_r[c] <= 4'h0;
						// [R12] [R13] per-channel enable
						trig_r[c] <= tsel_r[POS_TEN+TSEL_STEP*c];
					end else begin
						cnt_r[c] <= 4'(cnt_r[c] + 4'h1);
					end
				end
			end
		end
	end
	assign conversion_trigger_out_o = trig_r;

	property p_trig_enabled;
		@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(trig_r[1]) |-> $past(tsel_r[POS_TEN+TSEL_STEP]);
	endproperty
	a_trig_enabled: assert property (p_trig_enabled) // [R13]
		else $error("trigger B pulsed while disabled");

	property p_trig_clear;
		@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(trig_r[0]) |-> cnt_r[0] == 4'h0 && $past(src_hit[0]);
	endproperty
	a_trig_clear: assert property (p_trig_clear) // [R23]
		else $error("counter not cleared on trigger A");

	// [R18] delay shadows reload on own event
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			red_act_r <= '0;
			fed_act_r <= '0;
		end else if (ce_i) begin
			if (reload_hit(db_r[POS_LDRED +: 2], tb_evt_i)) begin
				red_act_r <= red_shd_r;
			end
			if (reload_hit(db_r[POS_LDFED +: 2], tb_evt_i)) begin
				fed_act_r <= fed_shd_r;
			end
		end
	end

	property p_red_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!tb_evt_i.zero && !tb_evt_i.period) |=> $stable(red_act_r);
	endproperty
	a_red_hold: assert property (p_red_hold) // [R18]
		else $error("rising delay loaded without event");

	// [R19] [R21] delay sources; dual edge chains both delays
	assign red_out = dly_out_r[0];
	assign fed_out = ~dly_out_r[1];
	assign dly_in[0] = db_r[POS_INM] ? aq_state_r[1] : aq_state_r[0];
	assign dly_in[1] = ~(db_r[POS_DEDB] ? red_out :
		(db_r[POS_INM+1] ? aq_state_r[1] : aq_state_r[0]));

	// [R16] [R17] [R24] edge delay counters; falling uses inverted input
	for (genvar g = 0; g < 2; g++) begin : g_dly
		logic prev_r;
		logic [DLY_W-1:0] cnt_d_r;
		logic [DLY_W:0] cnt_sum;
		logic [DLY_W-1:0] dly;
		assign dly = (g == 0) ? red_act_r : fed_act_r;
		assign cnt_sum = {1'b0, cnt_d_r} +
			(db_r[POS_HALF] ? (DLY_W+1)'(2) : (DLY_W+1)'(1));
		always_ff @(posedge core_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				prev_r <= 1'(g);
				cnt_d_r <= '0;
				dly_out_r[g] <= 1'(g);
			end else if (ce_i) begin
				prev_r <= dly_in[g];
				if (!dly_in[g]) begin
					dly_out_r[g] <= 1'b0;
				end else if (!prev_r) begin
					cnt_d_r <= '0;
					dly_out_r[g] <= (dly == '0);
				end else if (!dly_out_r[g]) begin
					cnt_d_r <= cnt_sum[DLY_W-1:0];
					dly_out_r[g] <= (cnt_sum >= {1'b0, dly});
				end
			end
		end
	end

	property p_dly_cut;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ce_i && !dly_in[0]) |=> !dly_out_r[0];
	endproperty
	a_dly_cut: assert property (p_dly_cut) // [R24]
		else $error("rising delay output high after source fell");

	// [R19] [R21] path select and polarity
	always_comb begin
		path_a = (db_r[POS_OUTM+1] ? red_out : aq_state_r[0]) ^
			db_r[POS_POL];
		if (db_r[POS_DEDB]) begin
			path_b = fed_out ^ db_r[POS_POL+1];
		end else begin
			path_b = (db_r[POS_OUTM] ? fed_out : aq_state_r[1]) ^
				db_r[POS_POL+1];
		end
	end

	// [R20] output swap routing
	always_comb begin
		case (db_r[POS_SWAP +: 2])
			SWP_A: {fin_a, fin_b} = {path_a, path_a};
			SWP_B: {fin_a, fin_b} = {path_b, path_b};
			SWP_CROSS: {fin_a, fin_b} = {path_b, path_a};
			default: {fin_a, fin_b} = {path_a, path_b};
		endcase
	end

	// Registered pin drivers
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulse_output_a_o <= 1'b0;
			pulse_output_b_o <= 1'b0;
		end else if (ce_i) begin
			pulse_output_a_o <= fin_a;
			pulse_output_b_o <= fin_b;
		end
	end

	property p_swap_cross;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ce_i && db_r[POS_SWAP +: 2] == SWP_CROSS)
			|=> pulse_output_a_o == $past(path_b);
	endproperty
	a_swap_cross: assert property (p_swap_cross) // [R20]
		else $error("crossed swap did not route B path to A");
endmodule

// >>> pwm_far_side.sv
// Far-side model: power stage switches and converter trigger input
`timescale 1ns/1ps
module pwm_far_side (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Watched lines
	input wire logic pulse_a_i,
	input wire logic [1:0] trig_i,
	// Observations
	output int trig_a_o,
	output int trig_b_o,
	output int width_a_o,
	output int rise_a_o
);
	int run_r;
	logic a_r;
	// Converter side counts start requests per channel
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trig_a_o <= 0;
			trig_b_o <= 0;
		end else begin
			trig_a_o <= trig_a_o + int'(trig_i[0]);
			trig_b_o <= trig_b_o + int'(trig_i[1]);
		end
	end
	// Switch A: last on-time and number of turn-ons
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_r <= 0;
			a_r <= 1'b0;
			width_a_o <= 0;
			rise_a_o <= 0;
		end else begin
			a_r <= pulse_a_i;
			if (pulse_a_i) begin
				run_r <= run_r + 1;
			end else if (run_r != 0) begin
				width_a_o <= run_r;
				run_r <= 0;
			end
			if (pulse_a_i && !a_r) begin
				rise_a_o <= rise_a_o + 1;
			end
		end
	end
endmodule

// >>> pwm_force_trigger_deadband_test.sv
// Self-checking bench for the force, trigger and dead-band back end
`timescale 1ns/1ps
module pwm_force_trigger_deadband_test;
	import pwm_back_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_s;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, out_a, out_b, dm;
	logic [1:0] trig, cc;
	logic [31:0] prev;
	logic [15:0] lfsr = 16'h4a2e;
	tb_evt_s evt;
	aq_evt_s aqa, aqb;
	int err_count = 0;
	int check_count = 0;
	int cnt_a, cnt_b, wa, ra, w0, r0;
	note_s q[$];
	note_s n;

	pwm_force_trigger_deadband DUT (.core_clk_i(clk), .rstn_i(rstn),
		.ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .tb_evt_i(evt),
		.aq_a_i(aqa), .aq_b_i(aqb), .pulse_output_a_o(out_a),
		.pulse_output_b_o(out_b), .conversion_trigger_out_o(trig));
	pwm_far_side far (.core_clk_i(clk), .rstn_i(rstn), .pulse_a_i(out_a),
		.trig_i(trig), .trig_a_o(cnt_a), .trig_b_o(cnt_b),
		.width_a_o(wa), .rise_a_o(ra));

	// Clock and reset
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
	end

	task automatic cmp_bus(string s, logic [31:0] e, logic [31:0] v);
		check_count++;
		if (v !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic cmp_cnt(string s, int e, int v);
		check_count++;
		if (v != e) begin
			err_count++;
			$display("MISMATCH %s expected %0d seen %0d", s, e, v);
		end
	endtask
	task automatic wrap_up();
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// APB transfer held until pready is seen
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m,
		logic er);
		q.push_back('{e, m, er});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// One-cycle event; z and p are output A actions riding on it
	task automatic pulse(logic [10:0] m, logic [1:0] z = 2'h0,
		logic [1:0] p = 2'h0);
		@(posedge clk);
		aqa.zero <= z;
		aqa.prd <= p;
		evt <= tb_evt_s'(m | {10'h000, dm});
		@(posedge clk);
		aqa.zero <= 2'h0;
		aqa.prd <= 2'h0;
		evt <= tb_evt_s'({10'h000, dm});
		repeat (4) @(posedge clk);
	endtask
	task automatic high(int w);
		@(posedge clk);
		aqa.level <= 1'b1;
		repeat (w) @(posedge clk);
		aqa.level <= 1'b0;
		repeat (25) @(posedge clk);
	endtask
	function automatic logic fx(logic [1:0] c, logic lv);
		return (c == ACT_LOW) ? 1'b0 : (c == ACT_HIGH) ? 1'b1 : lv;
	endfunction
	function automatic logic [15:0] nx(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Read results checked against the oldest note
	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
			&& pwrite === 1'b0) begin
			n = q.pop_front();
			cmp_bus("prdata", n.d & n.m, prdata & n.m);
			cmp_bus("pslverr", {31'h0, n.e}, {31'h0, pslverr});
		end
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		dm = 1'b0;
		evt = tb_evt_s'(11'h000);
		aqa = '0;
		aqb = '0;
		aqa.level = 1'b1;
		wait (rstn === 1'b1);
		rd(OFS_FORCE, 32'h0, 32'hffff_ffff, 1'b0);
		rd(OFS_TSEL, 32'h0, 32'hffff_ffff, 1'b0);
		rd(8'h40, 32'h0, 32'hffff_ffff, 1'b1);
		lfsr = nx(lfsr);
		wr(OFS_RED, {16'h0000, lfsr});
		rd(OFS_RED, {18'h0, lfsr[13:0]}, 32'hffff_ffff, 1'b0);
		// Forced levels under each reload event
		prev = 32'h0000_0040;
		for (int c = 0; c < 4; c++) begin
			cc = c[1:0];
			wr(OFS_RELOAD, (c > 1) ? 32'h2 : c);
			wr(OFS_FORCE, {28'h0, cc, cc});
			if (c < 2) pulse(c[0] ? 11'h400 : 11'h200);
			rd(OFS_STATUS, prev, 32'h0000_00ff, 1'b0);
			pulse(c[0] ? 11'h200 : 11'h400);
			prev = {24'h0, fx(cc, 1'b0), fx(cc, 1'b1), 2'b00, cc, cc};
			rd(OFS_STATUS, prev, 32'h0000_00ff, 1'b0);
		end
		// Trigger prescale, grouping and enables
		wr(OFS_TSEL, 32'h1c00);
		wr(OFS_PRESCALE, 32'h0200);
		repeat (3) pulse(11'h100);
		rd(OFS_PRESCALE, 32'h0600, 32'h0000_ffff, 1'b0);
		pulse(11'h100);
		cmp_cnt("trigger a", 2, cnt_a);
		cmp_cnt("trigger b", 0, cnt_b);
		wr(OFS_TSEL, 32'hcc20);
		wr(OFS_PRESCALE, 32'h2200);
		repeat (2) pulse(11'h010);
		cmp_cnt("trigger b", 1, cnt_b);
		cmp_cnt("trigger a", 2, cnt_a);
		wr(OFS_PRESCALE, 32'h2220);
		wr(OFS_EXT, 32'h0003);
		// Start value 1: two events reach the period of 3
		wr(OFS_INIT, 32'h0001);
		repeat (2) pulse(11'h100);
		cmp_cnt("trigger a", 3, cnt_a);
		// An event while the clock enable is low is lost
		ce <= 1'b0;
		pulse(11'h100);
		ce <= 1'b1;
		repeat (2) pulse(11'h100);
		cmp_cnt("frozen count", 3, cnt_a);
		// Dead-band rising delay, suppression and half step
		wr(OFS_DEADBAND_CONTROL, 32'h0000);
		@(posedge clk);
		aqa.level <= 1'b0;
		repeat (25) @(posedge clk);
		high(30);
		w0 = wa;
		wr(OFS_RED, 32'h000a);
		wr(OFS_DEADBAND_CONTROL, 32'h0002);
		pulse(11'h400);
		high(30);
		cmp_cnt("delayed width", w0 - 10, wa);
		r0 = ra;
		high(5);
		cmp_cnt("short pulse", r0, ra);
		wr(OFS_DEADBAND_CONTROL, 32'h8002);
		high(30);
		cmp_cnt("half width", w0 - 5, wa);
		// Dual edge: rising 10 then falling 4, crossed onto pin A
		wr(OFS_FED, 32'h0004);
		pulse(11'h400);
		wr(OFS_DEADBAND_CONTROL, 32'h7004);
		high(30);
		cmp_cnt("dual edge width", w0 - 10 + 4, wa);
		rd(OFS_STATUS, 32'h80, 32'h0000_00c0, 1'b0);
		// Down-count coincidence; actions ride on the events
		wr(OFS_DEADBAND_CONTROL, 32'h0000);
		dm = 1'b1;
		pulse(11'h200, 2'h0, ACT_HIGH);
		rd(OFS_STATUS, 32'h40, 32'h0000_0040, 1'b0);
		pulse(11'h600, ACT_LOW, ACT_HIGH);
		rd(OFS_STATUS, 32'h0, 32'h0000_0040, 1'b0);
		wrap_up();
	end
endmodule
